// ==== include/pdu_pkg.sv ====
// Constants, register map and state record of the peripheral DMA channel pair.
// Assumes a word-only AHB-Lite register bus and one system clock.
package pdu_pkg;

    localparam int unsigned PDU_DEC_W = 12;
    localparam int unsigned PDU_CNT_W = 16;

    // Byte offsets inside the served peripheral's space
    localparam logic [11:0] PDU_OFS_RX_ADDR   = 12'h100;
    localparam logic [11:0] PDU_OFS_RX_CNT    = 12'h104;
    localparam logic [11:0] PDU_OFS_TX_ADDR   = 12'h108;
    localparam logic [11:0] PDU_OFS_TX_CNT    = 12'h10c;
    localparam logic [11:0] PDU_OFS_RX_NADDR  = 12'h110;
    localparam logic [11:0] PDU_OFS_RX_NCNT   = 12'h114;
    localparam logic [11:0] PDU_OFS_TX_NADDR  = 12'h118;
    localparam logic [11:0] PDU_OFS_TX_NCNT   = 12'h11c;
    localparam logic [11:0] PDU_OFS_CTRL      = 12'h120;
    localparam logic [11:0] PDU_OFS_STATE     = 12'h124;

    // Control and status bit positions
    localparam int unsigned PDU_BIT_RX_EN  = 0;
    localparam int unsigned PDU_BIT_RX_DIS = 1;
    localparam int unsigned PDU_BIT_TX_EN  = 8;
    localparam int unsigned PDU_BIT_TX_DIS = 9;

    localparam logic [31:0] PDU_RST_WORD  = 32'h0000_0000;
    localparam logic [15:0] PDU_RST_CNT   = 16'h0000;
    localparam logic [2:0]  PDU_HSIZE_W   = 3'h2;

    // Transfer sizes on xfer_size
    localparam logic [1:0]  PDU_SZ_BYTE = 2'h0;
    localparam logic [1:0]  PDU_SZ_HALF = 2'h1;

    typedef enum logic [3:0] {
        PDU_R_RX_ADDR, PDU_R_RX_CNT, PDU_R_TX_ADDR, PDU_R_TX_CNT,
        PDU_R_RX_NADDR, PDU_R_RX_NCNT, PDU_R_TX_NADDR, PDU_R_TX_NCNT,
        PDU_R_CTRL, PDU_R_STATE, PDU_R_NONE
    } pdu_reg_e;

    typedef enum logic [1:0] {
        PDU_ST_IDLE, PDU_ST_RX_MEM, PDU_ST_TX_MEM
    } pdu_state_e;

    typedef struct packed {
        logic [31:0] rx_addr;
        logic [15:0] rx_cnt;
        logic [31:0] tx_addr;
        logic [15:0] tx_cnt;
        logic [31:0] rx_naddr;
        logic [15:0] rx_ncnt;
        logic [31:0] tx_naddr;
        logic [15:0] tx_ncnt;
        logic        rx_en;
        logic        tx_en;
        logic        rx_done;
        logic        tx_done;
        logic        rx_full;
        logic        tx_empty;
        pdu_state_e  state;
        logic        wr_pend;
        pdu_reg_e    wr_idx;
        logic [31:0] hrdata;
        logic        hreadyout;
        logic        hresp;
        logic        mem_req;
        logic        mem_write;
        logic [31:0] mem_addr;
        logic [1:0]  mem_size;
        logic [31:0] mem_wdata;
        logic [31:0] tx_data;
        logic        tx_load;
        logic        rx_taken;
    } pdu_state_s;

endpackage

// ==== src/pdu_channel_pair.sv ====
// Receive/transmit DMA channel pair for one serial peripheral, with its
// register block on AHB-Lite and a simple request/acknowledge memory port.
// Assumes the peripheral holds rx_ready/tx_ready until rx_taken/tx_load.
`timescale 1ns/1ps
`default_nettype none

module pdu_channel_pair #(
    parameter int unsigned DEC_W = 12
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output var  logic [31:0] hrdata,
    output var  logic        hreadyout,
    output var  logic        hresp,
    input  wire logic [1:0]  xfer_size,
    input  wire logic        rx_ready,
    input  wire logic [31:0] rx_data,
    output var  logic        rx_taken,
    input  wire logic        tx_ready,
    output var  logic [31:0] tx_data,
    output var  logic        tx_load,
    output var  logic        mem_req,
    output var  logic        mem_write,
    output var  logic [31:0] mem_addr,
    output var  logic [1:0]  mem_size,
    output var  logic [31:0] mem_wdata,
    input  wire logic [31:0] mem_rdata,
    input  wire logic        mem_ack,
    output var  logic        rx_buffer_done_flag,
    output var  logic        tx_buffer_done_flag,
    output var  logic        rx_all_buffers_full_flag,
    output var  logic        tx_all_buffers_empty_flag
);

    if (DEC_W < 9 || DEC_W > 32)
    begin : g_chk
        $error("DEC_W must cover offset 0x124 and fit haddr");
    end
    localparam pdu_pkg::pdu_state_s PDU_RST_STATE = '{
        rx_addr:   pdu_pkg::PDU_RST_WORD,
        rx_cnt:    pdu_pkg::PDU_RST_CNT,
        tx_addr:   pdu_pkg::PDU_RST_WORD,
        tx_cnt:    pdu_pkg::PDU_RST_CNT,
        rx_naddr:  pdu_pkg::PDU_RST_WORD,
        rx_ncnt:   pdu_pkg::PDU_RST_CNT,
        tx_naddr:  pdu_pkg::PDU_RST_WORD,
        tx_ncnt:   pdu_pkg::PDU_RST_CNT,
        rx_en:     1'b0,
        tx_en:     1'b0,
        rx_done:   1'b0,
        tx_done:   1'b0,
        rx_full:   1'b1,
        tx_empty:  1'b1,
        state:     pdu_pkg::PDU_ST_IDLE,
        wr_pend:   1'b0,
        wr_idx:    pdu_pkg::PDU_R_NONE,
        hrdata:    pdu_pkg::PDU_RST_WORD,
        hreadyout: 1'b1,
        hresp:     1'b0,
        mem_req:   1'b0,
        mem_write: 1'b0,
        mem_addr:  pdu_pkg::PDU_RST_WORD,
        mem_size:  2'h0,
        mem_wdata: pdu_pkg::PDU_RST_WORD,
        tx_data:   pdu_pkg::PDU_RST_WORD,
        tx_load:   1'b0,
        rx_taken:  1'b0
    };
    pdu_pkg::pdu_state_s st_ff;
    pdu_pkg::pdu_state_s nxt_st;
    function automatic logic [31:0] addr_step(input logic [1:0] sz);
        logic [31:0] s;
        s = 32'h0000_0004;
        if (sz == pdu_pkg::PDU_SZ_BYTE)
        begin
            s = 32'h0000_0001;
        end
        else if (sz == pdu_pkg::PDU_SZ_HALF)
        begin
            s = 32'h0000_0002;
        end
        return s;
    endfunction
    function automatic pdu_pkg::pdu_reg_e decode(input logic [DEC_W-1:0] a);
        pdu_pkg::pdu_reg_e r;
        r = pdu_pkg::PDU_R_NONE;
        if (a == DEC_W'(pdu_pkg::PDU_OFS_RX_ADDR))
        begin
            r = pdu_pkg::PDU_R_RX_ADDR;
        end
        else if (a == DEC_W'(pdu_pkg::PDU_OFS_RX_CNT))
        begin
            r = pdu_pkg::PDU_R_RX_CNT;
        end
        else if (a == DEC_W'(pdu_pkg::PDU_OFS_TX_ADDR))
        begin
            r = pdu_pkg::PDU_R_TX_ADDR;
        end
        else if (a == DEC_W'(pdu_pkg::PDU_OFS_TX_CNT))
        begin
            r = pdu_pkg::PDU_R_TX_CNT;
        end
        else if (a == DEC_W'(pdu_pkg::PDU_OFS_RX_NADDR))
        begin
            r = pdu_pkg::PDU_R_RX_NADDR;
        end
        else if (a == DEC_W'(pdu_pkg::PDU_OFS_RX_NCNT))
        begin
            r = pdu_pkg::PDU_R_RX_NCNT;
        end
        else if (a == DEC_W'(pdu_pkg::PDU_OFS_TX_NADDR))
        begin
            r = pdu_pkg::PDU_R_TX_NADDR;
        end
        else if (a == DEC_W'(pdu_pkg::PDU_OFS_TX_NCNT))
        begin
            r = pdu_pkg::PDU_R_TX_NCNT;
        end
        else if (a == DEC_W'(pdu_pkg::PDU_OFS_CTRL))
        begin
            r = pdu_pkg::PDU_R_CTRL;
        end
        else if (a == DEC_W'(pdu_pkg::PDU_OFS_STATE))
        begin
            r = pdu_pkg::PDU_R_STATE;
        end
        return r;
    endfunction
    logic rx_go;
    logic tx_go;
    logic rx_set_done;
    logic tx_set_done;
    logic addr_phase;
    pdu_pkg::pdu_reg_e rd_idx;
    assign rx_go = st_ff.rx_en && (st_ff.rx_cnt != 16'h0000) && rx_ready;
    assign tx_go = st_ff.tx_en && (st_ff.tx_cnt != 16'h0000) && tx_ready;
    assign addr_phase = hsel && hready && htrans[1];
    assign rd_idx = decode(haddr[DEC_W-1:0]);
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.tx_load = 1'b0;
        nxt_st.rx_taken = 1'b0;
        nxt_st.hrdata = 32'h0000_0000;
        nxt_st.hreadyout = 1'b1;
        nxt_st.hresp = 1'b0;
        rx_set_done = 1'b0;
        tx_set_done = 1'b0;
        // Engine; receive is served first when both are ready
        case (st_ff.state)
            pdu_pkg::PDU_ST_IDLE:
            begin
                if (rx_go)
                begin
                    nxt_st.state = pdu_pkg::PDU_ST_RX_MEM;
                    nxt_st.mem_req = 1'b1;
                    nxt_st.mem_write = 1'b1;
                    nxt_st.mem_addr = st_ff.rx_addr;
                    nxt_st.mem_size = xfer_size;
                    nxt_st.mem_wdata = rx_data;
                    nxt_st.rx_taken = 1'b1;
                end
                else if (tx_go)
                begin
                    nxt_st.state = pdu_pkg::PDU_ST_TX_MEM;
                    nxt_st.mem_req = 1'b1;
                    nxt_st.mem_write = 1'b0;
                    nxt_st.mem_addr = st_ff.tx_addr;
                    nxt_st.mem_size = xfer_size;
                end
                // Chaining waits for idle so a reload never races a transfer
                if (st_ff.rx_cnt == 16'h0000 && st_ff.rx_ncnt != 16'h0000)
                begin
                    nxt_st.rx_addr = st_ff.rx_naddr;
                    nxt_st.rx_cnt = st_ff.rx_ncnt;
                    nxt_st.rx_ncnt = 16'h0000;
                end
                if (st_ff.tx_cnt == 16'h0000 && st_ff.tx_ncnt != 16'h0000)
                begin
                    nxt_st.tx_addr = st_ff.tx_naddr;
                    nxt_st.tx_cnt = st_ff.tx_ncnt;
                    nxt_st.tx_ncnt = 16'h0000;
                end
            end
            pdu_pkg::PDU_ST_RX_MEM:
            begin
                if (mem_ack)
                begin
                    nxt_st.state = pdu_pkg::PDU_ST_IDLE;
                    nxt_st.mem_req = 1'b0;
                    nxt_st.rx_addr = st_ff.rx_addr + addr_step(st_ff.mem_size);
                    if (st_ff.rx_cnt != 16'h0000)
                    begin
                        nxt_st.rx_cnt = st_ff.rx_cnt - 16'h0001;
                        rx_set_done = (st_ff.rx_cnt == 16'h0001);
                    end
                end
            end
            pdu_pkg::PDU_ST_TX_MEM:
            begin
                if (mem_ack)
                begin
                    nxt_st.state = pdu_pkg::PDU_ST_IDLE;
                    nxt_st.mem_req = 1'b0;
                    nxt_st.tx_data = mem_rdata;
                    nxt_st.tx_load = 1'b1;
                    nxt_st.tx_addr = st_ff.tx_addr + addr_step(st_ff.mem_size);
                    if (st_ff.tx_cnt != 16'h0000)
                    begin
                        nxt_st.tx_cnt = st_ff.tx_cnt - 16'h0001;
                        tx_set_done = (st_ff.tx_cnt == 16'h0001);
                    end
                end
            end
            default:
            begin
                nxt_st.state = pdu_pkg::PDU_ST_IDLE;
                nxt_st.mem_req = 1'b0;
            end
        endcase

        // Register write data phase; software wins over the engine's update
        if (st_ff.wr_pend)
        begin
            case (st_ff.wr_idx)
                pdu_pkg::PDU_R_RX_ADDR:
                begin
                    nxt_st.rx_addr = hwdata;
                end
                pdu_pkg::PDU_R_RX_CNT:
                begin
                    nxt_st.rx_cnt = hwdata[15:0];
                    nxt_st.rx_done = 1'b0;
                end
                pdu_pkg::PDU_R_TX_ADDR:
                begin
                    nxt_st.tx_addr = hwdata;
                end
                pdu_pkg::PDU_R_TX_CNT:
                begin
                    nxt_st.tx_cnt = hwdata[15:0];
                    nxt_st.tx_done = 1'b0;
                end
                pdu_pkg::PDU_R_RX_NADDR:
                begin
                    nxt_st.rx_naddr = hwdata;
                end
                pdu_pkg::PDU_R_RX_NCNT:
                begin
                    nxt_st.rx_ncnt = hwdata[15:0];
                    nxt_st.rx_done = 1'b0;
                end
                pdu_pkg::PDU_R_TX_NADDR:
                begin
                    nxt_st.tx_naddr = hwdata;
                end
                pdu_pkg::PDU_R_TX_NCNT:
                begin
                    nxt_st.tx_ncnt = hwdata[15:0];
                    nxt_st.tx_done = 1'b0;
                end
                pdu_pkg::PDU_R_CTRL:
                begin
                    if (hwdata[pdu_pkg::PDU_BIT_RX_DIS])
                    begin
                        nxt_st.rx_en = 1'b0;
                    end
                    else if (hwdata[pdu_pkg::PDU_BIT_RX_EN])
                    begin
                        nxt_st.rx_en = 1'b1;
                    end
                    if (hwdata[pdu_pkg::PDU_BIT_TX_DIS])
                    begin
                        nxt_st.tx_en = 1'b0;
                    end
                    else if (hwdata[pdu_pkg::PDU_BIT_TX_EN])
                    begin
                        nxt_st.tx_en = 1'b1;
                    end
                end
                default:
                begin
                    nxt_st.wr_pend = 1'b0;
                end
            endcase
        end

        // A count reaching zero wins over a clearing write in the same cycle
        if (rx_set_done)
        begin
            nxt_st.rx_done = 1'b1;
        end
        if (tx_set_done)
        begin
            nxt_st.tx_done = 1'b1;
        end
        nxt_st.rx_full = (nxt_st.rx_cnt == 16'h0000) && (nxt_st.rx_ncnt == 16'h0000);
        nxt_st.tx_empty = (nxt_st.tx_cnt == 16'h0000) && (nxt_st.tx_ncnt == 16'h0000);

        // Address phase; reads sample the updated record so a read right
        // after a write returns the written value
        nxt_st.wr_pend = 1'b0;
        nxt_st.wr_idx = pdu_pkg::PDU_R_NONE;
        if (addr_phase)
        begin
            if (hwrite && hsize == pdu_pkg::PDU_HSIZE_W)
            begin
                nxt_st.wr_pend = 1'b1;
                nxt_st.wr_idx = rd_idx;
            end
            else if (!hwrite)
            begin
                case (rd_idx)
                    pdu_pkg::PDU_R_RX_ADDR:  nxt_st.hrdata = nxt_st.rx_addr;
                    pdu_pkg::PDU_R_RX_CNT:   nxt_st.hrdata = {16'h0000, nxt_st.rx_cnt};
                    pdu_pkg::PDU_R_TX_ADDR:  nxt_st.hrdata = nxt_st.tx_addr;
                    pdu_pkg::PDU_R_TX_CNT:   nxt_st.hrdata = {16'h0000, nxt_st.tx_cnt};
                    pdu_pkg::PDU_R_RX_NADDR: nxt_st.hrdata = nxt_st.rx_naddr;
                    pdu_pkg::PDU_R_RX_NCNT:  nxt_st.hrdata = {16'h0000, nxt_st.rx_ncnt};
                    pdu_pkg::PDU_R_TX_NADDR: nxt_st.hrdata = nxt_st.tx_naddr;
                    pdu_pkg::PDU_R_TX_NCNT:  nxt_st.hrdata = {16'h0000, nxt_st.tx_ncnt};
                    pdu_pkg::PDU_R_STATE:
                    begin
                        nxt_st.hrdata[pdu_pkg::PDU_BIT_RX_EN] = nxt_st.rx_en;
                        nxt_st.hrdata[pdu_pkg::PDU_BIT_TX_EN] = nxt_st.tx_en;
                    end
                    default:
                    begin
                        nxt_st.hrdata = 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    // Control register has no storage of its own, only the enables it steers
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_ff <= PDU_RST_STATE;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign hrdata = st_ff.hrdata;
    assign hreadyout = st_ff.hreadyout;
    assign hresp = st_ff.hresp;
    assign rx_taken = st_ff.rx_taken;
    assign tx_data = st_ff.tx_data;
    assign tx_load = st_ff.tx_load;
    assign mem_req = st_ff.mem_req;
    assign mem_write = st_ff.mem_write;
    assign mem_addr = st_ff.mem_addr;
    assign mem_size = st_ff.mem_size;
    assign mem_wdata = st_ff.mem_wdata;
    assign rx_buffer_done_flag = st_ff.rx_done;
    assign tx_buffer_done_flag = st_ff.tx_done;
    assign rx_all_buffers_full_flag = st_ff.rx_full;
    assign tx_all_buffers_empty_flag = st_ff.tx_empty;

endmodule

`default_nettype wire

// ==== sim/pdu_far_side.sv ====
// Far-side model: serial peripheral handshake plus a memory responder that stores nothing and reads back the inverted address.
// Memory answers in one cycle, or four when slow is set.
`timescale 1ns/1ps
`default_nettype none
module pdu_far_side (
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire logic        slow,
    input  wire logic        rx_go,
    input  wire logic        tx_go,
    input  wire logic        rx_taken,
    input  wire logic        tx_load,
    input  wire logic        mem_req,
    input  wire logic [31:0] mem_addr,
    output logic             mem_ack,
    output logic [31:0]      mem_rdata,
    output logic             rx_ready,
    output logic [31:0]      rx_data,
    output logic             tx_ready
);
    logic [1:0] wait_ff;
    // Outside the ack the bus shows another word, so stale data never matches
    assign mem_rdata = mem_ack ? ~mem_addr : mem_addr;
    assign tx_ready  = tx_go && !tx_load;
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wait_ff  <= 2'h0;
            mem_ack  <= 1'b0;
            rx_ready <= 1'b0;
            rx_data  <= 32'h0;
        end
        else
        begin
            mem_ack <= 1'b0;
            if (mem_req && !mem_ack)
            begin
                wait_ff <= wait_ff + 2'h1;
                if (!slow || wait_ff == 2'h3)
                begin
                    mem_ack <= 1'b1;
                    wait_ff <= 2'h0;
                end
            end
            rx_ready <= rx_go && !rx_taken;
            if (rx_taken)
                rx_data <= rx_data + 32'h1111_1111;
        end
    end
endmodule
`default_nettype wire

// ==== sim/pdu_channel_pair_assertions.sv ====
// Port-level checks of the DMA channel pair.
// Bound into every pdu_channel_pair; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module pdu_channel_pair_assertions (
    input wire logic        clk_sys,
    input wire logic        rst_b,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [1:0]  xfer_size,
    input wire logic        rx_ready,
    input wire logic [31:0] rx_data,
    input wire logic        rx_taken,
    input wire logic [31:0] tx_data,
    input wire logic        tx_load,
    input wire logic        mem_req,
    input wire logic        mem_write,
    input wire logic [31:0] mem_addr,
    input wire logic [1:0]  mem_size,
    input wire logic [31:0] mem_wdata,
    input wire logic [31:0] mem_rdata,
    input wire logic        mem_ack
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    AST_HREADY: assert property (hreadyout && !hresp)
        else $error("bus stalled or errored");
    AST_RD_IDLE: assert property (
        !$past(hsel && htrans[1] && !hwrite) |-> hrdata == 32'h0)
        else $error("read data outside a read");
    AST_SIZE: assert property ($rose(mem_req) |-> mem_size == $past(xfer_size))
        else $error("transfer size not taken");
    AST_RX_TAKE: assert property (rx_taken |-> mem_req && mem_write && $past(rx_ready))
        else $error("receive take without write");
    AST_WDATA: assert property (rx_taken |-> mem_wdata == $past(rx_data))
        else $error("receive item not written");
    AST_TX_LOAD: assert property (
        tx_load |-> tx_data == $past(mem_rdata) && $past(mem_ack && !mem_write))
        else $error("transmit load without read");
    AST_REQ_HOLD: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
        else $error("memory request dropped early");
    AST_ACK_DROP: assert property (mem_req && mem_ack |=> !mem_req)
        else $error("memory request held after ack");
    AST_PULSE: assert property (rx_taken |=> !rx_taken)
        else $error("receive take longer than a cycle");
endmodule
bind pdu_channel_pair pdu_channel_pair_assertions u_chk (.clk_sys, .rst_b, .hsel, .htrans,
    .hwrite, .hrdata, .hreadyout, .hresp, .xfer_size, .rx_ready, .rx_data, .rx_taken,
    .tx_data, .tx_load, .mem_req, .mem_write, .mem_addr, .mem_size, .mem_wdata, .mem_rdata,
    .mem_ack);
`default_nettype wire

// ==== sim/pdu_channel_pair_tb.sv ====
// Bench for the DMA channel pair: registers, control, chained receive, transmit.
// Far side is pdu_far_side; port checks arrive by bind.
`timescale 1ns/1ps
`default_nettype none
module pdu_channel_pair_tb;
    logic        clk_sys = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic        slow = 1'b0, rx_go = 1'b0, tx_go = 1'b0;
    logic [1:0]  htrans = 2'h0, xfer_size = 2'h2, mem_size;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, hrdata, rx_data, tx_data;
    logic [31:0] mem_addr, mem_wdata, mem_rdata;
    logic        hreadyout, hresp, rx_ready, rx_taken, tx_ready, tx_load;
    logic        mem_req, mem_write, mem_ack, rx_done, tx_done, rx_full, tx_empty;
    int          fail_count = 0, checks = 0, n_rx = 0, n_tx = 0, base;
    always #12.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
    begin
        n_rx <= n_rx + int'(rx_taken === 1'b1);
        n_tx <= n_tx + int'(tx_load === 1'b1);
    end
    pdu_channel_pair DUT (.clk_sys, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
        .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .xfer_size, .rx_ready,
        .rx_data, .rx_taken, .tx_ready, .tx_data, .tx_load, .mem_req, .mem_write, .mem_addr,
        .mem_size, .mem_wdata, .mem_rdata, .mem_ack, .rx_buffer_done_flag(rx_done),
        .tx_buffer_done_flag(tx_done), .rx_all_buffers_full_flag(rx_full),
        .tx_all_buffers_empty_flag(tx_empty));
    pdu_far_side u_far (.clk_sys, .rst_b, .slow, .rx_go, .tx_go, .rx_taken, .tx_load,
        .mem_req, .mem_addr, .mem_ack, .mem_rdata, .rx_ready, .rx_data, .tx_ready);
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Entered just after an edge; read data lands in rd
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic t_regs();
        logic [31:0] v;
        chk("full flag", rx_full, 1'b1);
        chk("empty flag", tx_empty, 1'b1);
        for (int i = 0; i < 10; i++)
        begin
            bus(1'b0, 12'h100 + 12'(4 * i), 32'h0);
            chk("reset value", rd, 32'h0);
        end
        for (int i = 0; i < 8; i++)
        begin
            bus(1'b1, 12'h100 + 12'(4 * i), 32'hfedc_ba98 ^ 32'(i));
            bus(1'b0, 12'h100 + 12'(4 * i), 32'h0);
            // Count registers keep only their low half
            v = (32'hfedc_ba98 ^ 32'(i)) & ((i % 2) ? 32'hffff : '1);
            chk("readback", rd, v);
        end
        bus(1'b1, 12'h128, 32'hffff_ffff);
        bus(1'b0, 12'h128, 32'h0);
        chk("unmapped", rd, 32'h0);
        bus(1'b1, 12'h124, 32'h0000_0101);
        bus(1'b0, 12'h124, 32'h0);
        chk("status write", rd, 32'h0);
        // Next counts first, so a cleared count cannot pull in a chained buffer
        for (int i = 7; i >= 0; i--)
            bus(1'b1, 12'h100 + 12'(4 * i), 32'h0);
        chk("all cleared", rx_full && tx_empty, 1'b1);
        $display("register test done");
    endtask
    task automatic t_ctrl();
        logic [31:0] cmd [9] = '{32'h1, 32'h0, 32'h3, 32'h101, 32'h200, 32'h300, 32'h100,
                                 32'h300, 32'h2};
        logic [31:0] st [9] = '{32'h1, 32'h1, 32'h0, 32'h101, 32'h1, 32'h1, 32'h101, 32'h1,
                                32'h0};
        for (int i = 0; i < 9; i++)
        begin
            bus(1'b1, 12'h120, cmd[i]);
            bus(1'b0, 12'h124, 32'h0);
            chk("enable state", rd, st[i]);
        end
        $display("control test done");
    endtask
    task automatic t_rx(input logic [1:0] sz);
        xfer_size <= sz;
        slow <= sz[0];
        bus(1'b1, 12'h100, 32'h2000_0000);
        bus(1'b1, 12'h104, 32'h2);
        bus(1'b1, 12'h110, 32'h3000_0000);
        bus(1'b1, 12'h114, 32'h1);
        base = n_rx;
        bus(1'b1, 12'h120, 32'h1);
        rx_go <= 1'b1;
        for (int i = 0; i < 200 && rx_full !== 1'b1; i++) @(posedge clk_sys);
        rx_go <= 1'b0;
        bus(1'b0, 12'h100, 32'h0);
        chk("rx items", 32'(n_rx - base), 32'h3);
        chk("rx addr", rd, 32'h3000_0000 + (32'h1 << sz));
        bus(1'b0, 12'h114, 32'h0);
        chk("rx next count", rd, 32'h0);
        chk("rx done", rx_done, 1'b1);
        bus(1'b1, 12'h104, 32'h0);
        repeat (2) @(posedge clk_sys);
        chk("rx done cleared", rx_done, 1'b0);
        bus(1'b1, 12'h120, 32'h2);
        $display("receive test done");
    endtask
    task automatic t_tx();
        xfer_size <= 2'h2;
        slow <= 1'b0;
        bus(1'b1, 12'h108, 32'h4000_0000);
        bus(1'b1, 12'h10c, 32'h2);
        base = n_tx;
        bus(1'b1, 12'h120, 32'h100);
        tx_go <= 1'b1;
        for (int i = 0; i < 200 && tx_empty !== 1'b1; i++) @(posedge clk_sys);
        repeat (20) @(posedge clk_sys);
        chk("tx items", 32'(n_tx - base), 32'h2);
        chk("tx data", tx_data, ~32'h4000_0004);
        bus(1'b0, 12'h108, 32'h0);
        chk("tx addr", rd, 32'h4000_0008);
        chk("tx done", tx_done, 1'b1);
        bus(1'b1, 12'h11c, 32'h0);
        repeat (2) @(posedge clk_sys);
        chk("tx done cleared", tx_done, 1'b0);
        bus(1'b1, 12'h120, 32'h200);
        bus(1'b1, 12'h10c, 32'h1);
        base = n_tx;
        repeat (20) @(posedge clk_sys);
        chk("tx while disabled", 32'(n_tx - base), 32'h0);
        tx_go <= 1'b0;
        $display("transmit test done");
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        t_regs();
        t_ctrl();
        for (int s = 0; s < 3; s++)
            t_rx(2'(s));
        t_tx();
        tally_and_finish();
    end
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        fail_count++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
